// >>> tbc_consts.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: apb byte address = 4 * register index
// Notes: none
`ifndef TBC_CONSTS_SVH
`define TBC_CONSTS_SVH
`define TBC_IDX_INTCTL 8'h0b
`define TBC_IDX_FLAGS 8'h0c
`define TBC_IDX_COUNT 8'h11
`define TBC_IDX_CTRL 8'h12
`define TBC_IDX_CCU_CTRL 8'h17
`define TBC_IDX_CCU_LOW 8'h15
`define TBC_IDX_CCU_HIGH 8'h16
`define TBC_IDX_IRQ_EN 8'h8c
`define TBC_IDX_PERIOD 8'h92
`define TBC_PERIOD_RST 8'hff
`define TBC_FLAG_MATCH 1
`define TBC_FLAG_EVENT 2
`define TBC_CTRL_RUN 2
`define TBC_CTRL_MASK 8'h7f
`define TBC_FLAGS_MASK 8'h7f
`define TBC_PRE4 4'h3
`define TBC_PRE16 4'hf
`endif

// >>> tbc_pkg.sv
// Purpose: types of the base timer and capture/compare unit
// Assumes: constants live in tbc_consts.svh
// Notes: none
package tbc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tbc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tbc_apb_rsp_t;
  typedef struct packed {
    logic out_a;
    logic out_b;
    logic out_c;
    logic out_d;
    logic oe_a_n;
    logic oe_bcd_n;
  } tbc_pins_t;
  typedef enum logic [1:0] {
    TBC_CLS_OFF = 2'b00,
    TBC_CLS_CAPTURE = 2'b01,
    TBC_CLS_COMPARE = 2'b10,
    TBC_CLS_PWM = 2'b11
  } tbc_class_t;
  typedef struct packed {
    logic [7:0] intctl;
    logic [7:0] flags;
    logic [7:0] irq_en;
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [7:0] period;
    logic [7:0] ccu_ctrl;
    logic [7:0] val_low;
    logic [7:0] val_high;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [3:0] cap_pre;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic cmp_latch;
    logic match_pulse;
    logic special_trig;
    logic [1:0] duty_lsb_buf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tbc_state_t;
endpackage

// >>> tbc_core.sv
// Purpose: 8-bit base timer with pre/postscaler and capture/compare unit control
// Assumes: apb slave, zero-wait-state answer; capture timebase supplied from outside
// Notes: pwm waveform, deadband and detailed compare timing live elsewhere
`timescale 1ns/1ps
`include "tbc_consts.svh"

module tbc_core (
  input wire logic clk,
  input wire logic rst_n,
  input tbc_pkg::tbc_apb_req_t apb_req,
  output tbc_pkg::tbc_apb_rsp_t apb_rsp,
  input wire logic [15:0] capture_timebase,
  input wire logic ccu_pin_in,
  input wire logic adc_enabled,
  input wire logic pwm_wave,
  output logic timebase_reset,
  output logic adc_start,
  output logic sync_serial_unit_clk,
  output logic base_timer_match_flag,
  output logic ccu_event_flag,
  output logic [9:0] pwm_duty,
  output tbc_pkg::tbc_pins_t pins
);

  function automatic tbc_pkg::tbc_class_t mode_class(input logic [3:0] m);
    if (m[3:2] == 2'b11)
      mode_class = tbc_pkg::TBC_CLS_PWM;
    else if (m[3:2] == 2'b01)
      mode_class = tbc_pkg::TBC_CLS_CAPTURE;
    else if (m[3] || m == 4'h2)
      mode_class = tbc_pkg::TBC_CLS_COMPARE;
    else
      mode_class = tbc_pkg::TBC_CLS_OFF;
  endfunction

  tbc_pkg::tbc_state_t s_r;
  tbc_pkg::tbc_state_t s_nxt;
  tbc_pkg::tbc_class_t cls;
  logic [7:0] idx;
  logic setup;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic pre_tick;
  logic period_hit;
  logic cap_event;
  logic cmp_match;
  logic [3:0] pre_lim;
  logic [7:0] rdv;
  logic pol_ac;
  logic pol_bd;

  // ************************************************************
  // register access decode
  // ************************************************************
  always_comb
  begin
    idx = apb_req.paddr[9:2];
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_r.pready;
    rd = setup && !apb_req.pwrite;
    wbyte = apb_req.pwdata[7:0];
    cls = mode_class(s_r.ccu_ctrl[3:0]);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.match_pulse = 1'b0;
    s_nxt.special_trig = 1'b0;
    // prescaler tick
    unique case (s_r.ctrl[1:0])
      2'b00: pre_lim = 4'h0;
      2'b01: pre_lim = `TBC_PRE4;
      default: pre_lim = `TBC_PRE16;
    endcase
    pre_tick = s_r.ctrl[`TBC_CTRL_RUN] && (s_r.pre_cnt >= pre_lim);
    period_hit = pre_tick && (s_r.count == s_r.period);
    if (s_r.ctrl[`TBC_CTRL_RUN])
    begin
      s_nxt.pre_cnt = pre_tick ? 4'h0 : s_r.pre_cnt + 4'h1;
    end
    if (pre_tick)
    begin
      s_nxt.count = period_hit ? 8'h00 : s_r.count + 8'h01;
    end
    if (period_hit)
    begin
      s_nxt.match_pulse = 1'b1;
      if (s_r.post_cnt >= s_r.ctrl[6:3])
      begin
        s_nxt.post_cnt = 4'h0;
        s_nxt.flags[`TBC_FLAG_MATCH] = 1'b1;
      end
      else
        s_nxt.post_cnt = s_r.post_cnt + 4'h1;
    end
    if (s_r.pready)
    begin
      if (s_r.ccu_ctrl[3:0] == 4'h0)
      begin
        s_nxt.cmp_latch = 1'b0;
      end
    end
    // pin synchronizer and edge detect
    s_nxt.pin_s1 = ccu_pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_prev = s_r.pin_s2;
    cap_event = 1'b0;
    if (cls == tbc_pkg::TBC_CLS_CAPTURE)
    begin
      if (s_r.pin_s2 && !s_r.pin_prev && s_r.ccu_ctrl[1])
      begin
        if (s_r.cap_pre >= (s_r.ccu_ctrl[0] ? `TBC_PRE16 : `TBC_PRE4))
        begin
          s_nxt.cap_pre = 4'h0;
          cap_event = 1'b1;
        end
        else
          s_nxt.cap_pre = s_r.cap_pre + 4'h1;
      end
      else if (!s_r.ccu_ctrl[1])
        cap_event = s_r.ccu_ctrl[0] ? (s_r.pin_s2 && !s_r.pin_prev)
                                    : (!s_r.pin_s2 && s_r.pin_prev);
    end
    else
      s_nxt.cap_pre = 4'h0;
    if (cap_event)
    begin
      s_nxt.val_low = capture_timebase[7:0];
      s_nxt.val_high = capture_timebase[15:8];
      s_nxt.flags[`TBC_FLAG_EVENT] = 1'b1;
    end
    // compare against the timebase
    cmp_match = (cls == tbc_pkg::TBC_CLS_COMPARE)
                && (capture_timebase == {s_r.val_high, s_r.val_low});
    if (cmp_match && !s_r.special_trig)
    begin
      s_nxt.flags[`TBC_FLAG_EVENT] = 1'b1;
      unique case (s_r.ccu_ctrl[3:0])
        4'h2: s_nxt.cmp_latch = !s_r.cmp_latch;
        4'h8: s_nxt.cmp_latch = 1'b1;
        4'h9: s_nxt.cmp_latch = 1'b0;
        4'hb: s_nxt.special_trig = 1'b1;
        default: s_nxt.cmp_latch = s_r.cmp_latch;
      endcase
    end
    // pwm duty buffering at period end
    if (cls == tbc_pkg::TBC_CLS_PWM && period_hit)
    begin
      s_nxt.val_high = s_r.val_low;
      s_nxt.duty_lsb_buf = s_r.ccu_ctrl[5:4];
    end
    // apb: no wait state, answer in access phase
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    if (setup)
    begin
      s_nxt.prdata = 32'h0;
      if (rd)
        s_nxt.prdata = {24'h0, rdv};
    end
    if (wr)
    begin
      unique case (idx)
        `TBC_IDX_INTCTL: s_nxt.intctl = wbyte;
        `TBC_IDX_FLAGS: s_nxt.flags = (wbyte & `TBC_FLAGS_MASK) | (s_nxt.flags & ~s_r.flags);
        `TBC_IDX_IRQ_EN: s_nxt.irq_en = wbyte & `TBC_FLAGS_MASK;
        `TBC_IDX_COUNT:
        begin
          s_nxt.count = wbyte;
          s_nxt.pre_cnt = 4'h0;
          s_nxt.post_cnt = 4'h0;
        end
        `TBC_IDX_CTRL:
        begin
          s_nxt.ctrl = wbyte & `TBC_CTRL_MASK;
          s_nxt.pre_cnt = 4'h0;
          s_nxt.post_cnt = 4'h0;
        end
        `TBC_IDX_PERIOD: s_nxt.period = wbyte;
        `TBC_IDX_CCU_CTRL:
        begin
          s_nxt.ccu_ctrl = wbyte;
          if (wbyte[3:0] == 4'h0)
          begin
            s_nxt.cmp_latch = 1'b0;
            s_nxt.cap_pre = 4'h0;
          end
          else if (wbyte[3:0] == 4'h8)
            s_nxt.cmp_latch = 1'b1;
          else if (wbyte[3:0] == 4'h9)
            s_nxt.cmp_latch = 1'b0;
        end
        `TBC_IDX_CCU_LOW: s_nxt.val_low = wbyte;
        `TBC_IDX_CCU_HIGH:
        begin
          if (cls != tbc_pkg::TBC_CLS_PWM)
            s_nxt.val_high = wbyte;
        end
        default: s_nxt.pslverr = 1'b0;
      endcase
    end
    if (setup && !(idx inside {`TBC_IDX_INTCTL, `TBC_IDX_FLAGS, `TBC_IDX_IRQ_EN,
        `TBC_IDX_COUNT, `TBC_IDX_CTRL, `TBC_IDX_PERIOD, `TBC_IDX_CCU_CTRL,
        `TBC_IDX_CCU_LOW, `TBC_IDX_CCU_HIGH}))
      s_nxt.pslverr = 1'b1;
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb
  begin
    unique case (idx)
      `TBC_IDX_INTCTL: rdv = s_r.intctl;
      `TBC_IDX_FLAGS: rdv = s_r.flags;
      `TBC_IDX_IRQ_EN: rdv = s_r.irq_en;
      `TBC_IDX_COUNT: rdv = s_r.count;
      `TBC_IDX_CTRL: rdv = s_r.ctrl;
      `TBC_IDX_PERIOD: rdv = s_r.period;
      `TBC_IDX_CCU_CTRL: rdv = s_r.ccu_ctrl;
      `TBC_IDX_CCU_LOW: rdv = s_r.val_low;
      `TBC_IDX_CCU_HIGH: rdv = s_r.val_high;
      default: rdv = 8'h00;
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.period <= `TBC_PERIOD_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ************************************************************
  // outputs and pin steering
  // ************************************************************
  always_comb
  begin
    apb_rsp.pready = s_r.pready;
    apb_rsp.pslverr = s_r.pslverr;
    apb_rsp.prdata = s_r.prdata;
    timebase_reset = s_r.special_trig;
    adc_start = s_r.special_trig && adc_enabled;
    sync_serial_unit_clk = s_r.match_pulse;
    base_timer_match_flag = s_r.flags[`TBC_FLAG_MATCH];
    ccu_event_flag = s_r.flags[`TBC_FLAG_EVENT];
    pwm_duty = {s_r.val_high, s_r.duty_lsb_buf};
    pol_ac = s_r.ccu_ctrl[1];
    pol_bd = s_r.ccu_ctrl[0];
    pins.out_a = 1'b0;
    pins.out_b = 1'b0;
    pins.out_c = 1'b0;
    pins.out_d = 1'b0;
    pins.oe_a_n = 1'b1;
    pins.oe_bcd_n = 1'b1;
    if (cls == tbc_pkg::TBC_CLS_COMPARE)
    begin
      pins.out_a = s_r.cmp_latch;
      pins.oe_a_n = 1'b0;
    end
    else if (cls == tbc_pkg::TBC_CLS_PWM)
    begin
      pins.oe_a_n = 1'b0;
      unique case (s_r.ccu_ctrl[7:6])
        2'b00: pins.out_a = pwm_wave ^ pol_ac;
        2'b01:
        begin
          pins.out_a = !pol_ac;
          pins.out_b = pol_bd;
          pins.out_c = pol_ac;
          pins.out_d = pwm_wave ^ pol_bd;
          pins.oe_bcd_n = 1'b0;
        end
        2'b10:
        begin
          pins.out_a = pwm_wave ^ pol_ac;
          pins.out_b = !pwm_wave ^ pol_bd;
          pins.oe_bcd_n = 1'b0;
        end
        2'b11:
        begin
          pins.out_a = pol_ac;
          pins.out_b = pwm_wave ^ pol_bd;
          pins.out_c = !pol_ac;
          pins.out_d = pol_bd;
          pins.oe_bcd_n = 1'b0;
        end
      endcase
    end
  end

endmodule // tbc_core

// >>> tbc_core_asserts.sv
// Purpose: port checks of tbc_core
// Assumes: mode mirror follows apb writes
// Notes: none
`timescale 1ns/1ps
// ****
// checker
// ****
module tbc_core_asserts (
  input logic clk,
  input logic rst_n,
  input tbc_pkg::tbc_apb_req_t apb_req,
  input tbc_pkg::tbc_apb_rsp_t apb_rsp,
  input logic adc_enabled,
  input logic timebase_reset,
  input logic adc_start,
  input logic base_timer_match_flag,
  input logic ccu_event_flag
);
  logic [3:0] mode_r;
  logic wr;
  assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= 4'h0;
    else if (wr && apb_req.paddr[9:2] == 8'h17)
      mode_r <= apb_req.pwdata[3:0];
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready");
  a_ready_one: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("long ready");
  a_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("error data");
  a_adc_gate: assert property (adc_start == (timebase_reset && adc_enabled))
    else $error("adc start");
  a_trig_single: assert property (timebase_reset |=> !timebase_reset)
    else $error("trigger width");
  a_trig_mode: assert property (timebase_reset |-> mode_r == 4'hb || $past(mode_r) == 4'hb)
    else $error("trigger mode");
  a_match_sticky: assert property (base_timer_match_flag && !wr |=> base_timer_match_flag)
    else $error("match flag lost");
  a_event_sticky: assert property (ccu_event_flag && !wr |=> ccu_event_flag)
    else $error("event flag lost");
endmodule // tbc_core_asserts
bind tbc_core tbc_core_asserts u_chk (.clk, .rst_n, .apb_req, .apb_rsp, .adc_enabled,
  .timebase_reset, .adc_start, .base_timer_match_flag, .ccu_event_flag);

// >>> tbc_src_model.sv
// Purpose: capture pin source and synchronous timebase
// Assumes: timebase holds load_val while stopped
// Notes: none
`timescale 1ns/1ps
// ****
// source model
// ****
module tbc_src_model (
  input logic clk,
  input logic rst_n,
  input logic timebase_reset,
  input logic run,
  input logic [15:0] load_val,
  input logic pin_lvl,
  output logic [15:0] capture_timebase,
  output logic ccu_pin_in
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_timebase <= 16'h0;
      ccu_pin_in <= 1'b0;
    end
    else
    begin
      ccu_pin_in <= pin_lvl;
      if (timebase_reset)
        capture_timebase <= 16'h0;
      else if (run)
        capture_timebase <= capture_timebase + 16'h1;
      else
        capture_timebase <= load_val;
    end
  end
endmodule // tbc_src_model

// >>> timebase_and_ccu_control_tb.sv
// Purpose: self-checking bench of tbc_core
// Assumes: zero-wait-state apb slave
// Notes: random values from a fixed seed
`timescale 1ns/1ps
`include "tbc_consts.svh"
// ****
// bench
// ****
module timebase_and_ccu_control_tb;
  logic clk, rst_n, adc_enabled, pwm_wave, run, pin, timebase_reset, ssu, mflag, eflag, e;
  logic ccu_pin_in, a0, ex;
  logic [15:0] ld, capture_timebase, v;
  logic [9:0] pwm_duty;
  logic [31:0] r;
  logic [7:0] p, d, q;
  int c, n, err_total = 0, checks_done = 0, trig_n = 0;
  integer seed = 32'h695d37dc;
  logic [7:0] ri [7] = '{`TBC_IDX_INTCTL, `TBC_IDX_FLAGS, `TBC_IDX_COUNT, `TBC_IDX_CTRL,
    `TBC_IDX_CCU_CTRL, `TBC_IDX_IRQ_EN, `TBC_IDX_PERIOD};
  logic [3:0] cm [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
  tbc_pkg::tbc_apb_req_t apb_req;
  tbc_pkg::tbc_apb_rsp_t apb_rsp;
  tbc_pkg::tbc_pins_t pins;
  tbc_core dut (.clk, .rst_n, .apb_req, .apb_rsp, .capture_timebase, .ccu_pin_in,
    .adc_enabled, .pwm_wave, .timebase_reset, .adc_start(), .sync_serial_unit_clk(ssu),
    .base_timer_match_flag(mflag), .ccu_event_flag(eflag), .pwm_duty, .pins);
  tbc_src_model src (.clk, .rst_n, .timebase_reset, .run, .load_val(ld), .pin_lvl(pin),
    .capture_timebase, .ccu_pin_in);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    adc_enabled <= 1'($random(seed));
    pwm_wave <= 1'($random(seed));
    if (timebase_reset === 1'b1)
      trig_n++;
  end
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
    int k;
    k = 0;
    apb_req <= '{1'b1, 1'b0, w, {2'b00, ix, 2'b00}, {24'h0, wd}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (apb_rsp.pready !== 1'b1 && k < 50);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    // one idle edge, so a following call never reassigns the request in this time step
    @(posedge clk);
    if (k == 50)
      err_total++;
  endtask
  task automatic chk(input string nm, input logic [31:0] xv, input logic [31:0] got);
    checks_done++;
    if (got !== xv)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, xv, got);
    end
  endtask
  task automatic rdk(input string nm, input logic [7:0] ix, input logic [31:0] xv);
    apb(1'b0, ix, 8'h0);
    chk(nm, xv, r);
  endtask
  task automatic wait_ssu(output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ssu !== 1'b1 && k < 3000);
  endtask
  task automatic pulses(input int k);
    repeat (k)
    begin
      pin <= 1'b1;
      repeat (5) @(posedge clk);
      pin <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  function automatic int divf(input logic [1:0] k);
    return k == 2'd0 ? 1 : k == 2'd1 ? 4 : 16;
  endfunction
  function automatic logic cmpf(input logic [3:0] m, input logic old);
    return m == 4'h8 ? 1'b1 : m == 4'h9 ? 1'b0 : m == 4'h2 ? !old : old;
  endfunction
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 0;
    apb_req = '0;
    adc_enabled = 0;
    pwm_wave = 0;
    run = 0;
    ld = 0;
    pin = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ri[i])
      rdk("reset", ri[i], {24'h0, i == 6 ? 8'hff : 8'h00});
    apb(1'b0, 8'h40, 8'h0);
    chk("slverr", 1, e);
    for (int k = 0; k < 4; k++)
    begin
      p = 8'd3 + 8'($random(seed) & 3);
      q = 8'($random(seed) & 15);
      apb(1'b1, `TBC_IDX_CTRL, 8'h00);
      apb(1'b1, `TBC_IDX_PERIOD, p);
      apb(1'b1, `TBC_IDX_COUNT, 8'h00);
      apb(1'b1, `TBC_IDX_FLAGS, 8'h00);
      apb(1'b1, `TBC_IDX_CTRL, {1'b0, q[3:0], 1'b1, 2'(k)});
      n = 0;
      for (c = 0; c < 3000 && mflag !== 1'b1; c++)
      begin
        @(posedge clk);
        n += ssu;
      end
      repeat (2)
      begin
        @(posedge clk);
        n += ssu;
      end
      chk("post", q + 1, n);
      wait_ssu(c);
      wait_ssu(c);
      chk("period", (p + 1) * divf(2'(k)), c);
      apb(1'b1, `TBC_IDX_CTRL, {1'b0, q[3:0], 3'(k)});
      apb(1'b0, `TBC_IDX_COUNT, 8'h0);
      d = r[7:0];
      repeat (20) @(posedge clk);
      apb(1'b1, `TBC_IDX_CTRL, 8'h78);
      rdk("hold", `TBC_IDX_COUNT, {24'h0, d});
    end
    apb(1'b1, `TBC_IDX_COUNT, 8'h5a);
    rdk("count", `TBC_IDX_COUNT, 32'h5a);
    for (int m = 4; m < 8; m++)
    begin
      n = m == 6 ? 4 : m == 7 ? 16 : 1;
      ld <= 16'($random(seed));
      apb(1'b1, `TBC_IDX_CCU_CTRL, 8'h00);
      apb(1'b1, `TBC_IDX_CCU_CTRL, 8'(m));
      apb(1'b1, `TBC_IDX_FLAGS, 8'h00);
      pulses(n - 1);
      chk("early", 0, eflag);
      pulses(1);
      chk("event", 1, eflag);
      v = 16'($random(seed));
      ld <= v;
      pulses(n);
      rdk("cap_lo", `TBC_IDX_CCU_LOW, {24'h0, v[7:0]});
      rdk("cap_hi", `TBC_IDX_CCU_HIGH, {24'h0, v[15:8]});
      chk("kept", 1, eflag);
    end
    foreach (cm[i])
    begin
      v = 16'h0100 + 16'($random(seed) & 16'h0fff);
      ld <= v - 16'd8;
      apb(1'b1, `TBC_IDX_CCU_CTRL, 8'h00);
      apb(1'b1, `TBC_IDX_CCU_LOW, v[7:0]);
      apb(1'b1, `TBC_IDX_CCU_HIGH, v[15:8]);
      apb(1'b1, `TBC_IDX_CCU_CTRL, {4'h0, cm[i]});
      apb(1'b1, `TBC_IDX_FLAGS, 8'h00);
      a0 = pins.out_a;
      trig_n = 0;
      run <= 1'b1;
      for (c = 0; c < 40 && eflag !== 1'b1; c++)
        @(posedge clk);
      repeat (2) @(posedge clk);
      run <= 1'b0;
      ex = cmpf(cm[i], a0);
      chk("cmp_flag", 1, eflag);
      chk("cmp_pin", ex, pins.out_a);
      if (cm[i] == 4'hb)
        chk("trig", 1, trig_n);
    end
    apb(1'b1, `TBC_IDX_PERIOD, 8'h05);
    apb(1'b1, `TBC_IDX_COUNT, 8'h00);
    apb(1'b1, `TBC_IDX_CTRL, 8'h04);
    for (int s = 0; s < 4; s++)
    begin
      d = 8'($random(seed));
      q = 8'($random(seed));
      apb(1'b1, `TBC_IDX_CCU_LOW, d);
      apb(1'b1, `TBC_IDX_CCU_CTRL, {2'(s), q[1:0], 2'b11, q[3:2]});
      wait_ssu(c);
      wait_ssu(c);
      chk("duty", {22'h0, d, q[1:0]}, pwm_duty);
      chk("oe_a", 0, pins.oe_a_n);
      chk("oe_bcd", (s == 0) ? 1 : 0, pins.oe_bcd_n);
      if (s == 1)
        chk("fwd_a", {31'h0, !q[3]}, pins.out_a);
    end
    complete_run();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule // timebase_and_ccu_control_tb
